/* File: design/accel_inactivity_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module accel_inactivity_detect #(
	parameter int SLOW_CODE_CYCLES = rest_pkg::CODE_CYCLES_SLOW,
	parameter int FAST_CODE_CYCLES = rest_pkg::CODE_CYCLES_FAST
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic outputDataRateFast,
	input wire logic sampleValid,
	input wire logic signed [11:0] sampleX,
	input wire logic signed [11:0] sampleY,
	input wire logic signed [11:0] sampleZ,
	output logic restDetected,
	output logic restEvent,
	output logic [1:0] restState
);
	localparam int AXES = rest_pkg::AXES;
	localparam int SW = rest_pkg::SAMPLE_W;
	localparam int CW = rest_pkg::COUNT_W;

	// register storage, reserved bits are not stored
	logic [7:0] thrHigh [AXES];
	logic [2:0] thrLow [AXES];
	logic [AXES-1:0] restUseAxis;
	logic restReferencedSelect;
	logic [7:0] timeHigh;
	logic [7:0] timeLow;
	logic signed [SW-1:0] refSample [AXES];

	rest_pkg::rest_state_t state;
	rest_pkg::rest_state_t next_state;
	logic [CW-1:0] stillCount;

	wire logic signed [SW-1:0] sample [AXES];
	wire logic [10:0] restThreshold [AXES];
	wire logic [AXES-1:0] overAxis;
	wire logic [CW-1:0] stillnessTimeValue = {timeHigh, timeLow};
	wire logic codeTick;

	assign sample[0] = sampleX;
	assign sample[1] = sampleY;
	assign sample[2] = sampleZ;

	function automatic logic [SW:0] absMag(input logic signed [SW:0] v);
		absMag = v[SW] ? (SW + 1)'(-v) : (SW + 1)'(v);
	endfunction

	genvar i;
	generate
		for (i = 0; i < AXES; i++) begin : g_axis
			wire logic writeHigh = regWrEn && (regAddr == rest_pkg::ADDR_HIGH[i]);
			wire logic writeLow = regWrEn && (regAddr == rest_pkg::ADDR_LOW[i]);
			wire logic signed [SW:0] sampleExt = (SW + 1)'(sample[i]);
			wire logic signed [SW:0] refExt = (SW + 1)'(refSample[i]);
			wire logic signed [SW:0] diff = restReferencedSelect ? (SW + 1)'(sampleExt - refExt) : sampleExt;
			wire logic [SW:0] mag = absMag(diff);

			assign restThreshold[i] = {thrHigh[i], thrLow[i]};
			// threshold codes share the sample scale, so no rescaling
			assign overAxis[i] = restUseAxis[i] && (mag >= (SW + 1)'(restThreshold[i]));

			always_ff @(posedge sys_clk) begin
				if (srst) begin
					thrHigh[i] <= rest_pkg::REG_RESET;
					thrLow[i] <= '0;
					restUseAxis[i] <= 1'b0;
				end else if (writeHigh) begin
					thrHigh[i] <= regWrData;
				end else if (writeLow) begin
					thrLow[i] <= regWrData[rest_pkg::THR_LOW_MSB:rest_pkg::THR_LOW_LSB];
					restUseAxis[i] <= regWrData[rest_pkg::USE_BIT];
				end
			end

			// reference is reloaded from every sample taken while in ST_IDLE
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					refSample[i] <= '0;
				end else if (state == rest_pkg::ST_IDLE && sampleValid) begin
					refSample[i] <= sample[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			restReferencedSelect <= 1'b0;
			timeHigh <= rest_pkg::REG_RESET;
			timeLow <= rest_pkg::REG_RESET;
		end else if (regWrEn && regAddr == rest_pkg::ADDR_X_LOW) begin
			restReferencedSelect <= regWrData[rest_pkg::REF_BIT];
		end else if (regWrEn && regAddr == rest_pkg::ADDR_TIME_HIGH) begin
			timeHigh <= regWrData;
		end else if (regWrEn && regAddr == rest_pkg::ADDR_TIME_LOW) begin
			timeLow <= regWrData;
		end
	end

	function automatic logic [7:0] lowByte(input int a);
		lowByte = {thrLow[a], 3'h0, (a == 0) ? restReferencedSelect : 1'b0, restUseAxis[a]};
	endfunction

	function automatic logic [7:0] readReg(input logic [7:0] a);
		if (a == rest_pkg::ADDR_X_HIGH) begin
			readReg = thrHigh[0];
		end else if (a == rest_pkg::ADDR_X_LOW) begin
			readReg = lowByte(0);
		end else if (a == rest_pkg::ADDR_Y_HIGH) begin
			readReg = thrHigh[1];
		end else if (a == rest_pkg::ADDR_Y_LOW) begin
			readReg = lowByte(1);
		end else if (a == rest_pkg::ADDR_Z_HIGH) begin
			readReg = thrHigh[2];
		end else if (a == rest_pkg::ADDR_Z_LOW) begin
			readReg = lowByte(2);
		end else if (a == rest_pkg::ADDR_TIME_HIGH) begin
			readReg = timeHigh;
		end else if (a == rest_pkg::ADDR_TIME_LOW) begin
			readReg = timeLow;
		end else begin
			readReg = 8'h00;
		end
	endfunction

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= readReg(regAddr);
		end
	end

	wire logic anyUse = |restUseAxis;
	wire logic overHit = sampleValid && |overAxis;
	wire logic belowHit = sampleValid && !(|overAxis);

	// timer codes run only while watching; the 6400 Hz rate halves the code
	code_tick_divider #(
		.SLOW_CYCLES(SLOW_CODE_CYCLES),
		.FAST_CYCLES(FAST_CODE_CYCLES)
	) u_tick (
		.sys_clk(sys_clk),
		.srst(srst),
		.clear(state != rest_pkg::ST_WATCH),
		.fast(outputDataRateFast),
		.tick(codeTick)
	);

	always_comb begin
		next_state = state;
		case (state)
			rest_pkg::ST_IDLE: begin
				if (anyUse && belowHit) begin
					next_state = rest_pkg::ST_WATCH;
				end
			end
			rest_pkg::ST_WATCH: begin
				if (!anyUse || overHit) begin
					next_state = rest_pkg::ST_IDLE;
				end else if (stillCount >= stillnessTimeValue) begin
					next_state = rest_pkg::ST_STILL;
				end
			end
			rest_pkg::ST_STILL: begin
				if (!anyUse || overHit) begin
					next_state = rest_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = rest_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= rest_pkg::ST_IDLE;
			stillCount <= '0;
		end else begin
			state <= next_state;
			if (next_state == rest_pkg::ST_IDLE || state == rest_pkg::ST_IDLE) begin
				stillCount <= '0;
			end else if (codeTick && state == rest_pkg::ST_WATCH && stillCount != '1) begin
				stillCount <= stillCount + CW'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			restDetected <= 1'b0;
			restEvent <= 1'b0;
			restState <= 2'b00;
		end else begin
			restDetected <= (next_state == rest_pkg::ST_STILL);
			restEvent <= (next_state == rest_pkg::ST_STILL) && (state != rest_pkg::ST_STILL);
			restState <= next_state;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence watchOver;
		state == rest_pkg::ST_WATCH && overHit;
	endsequence
	sequence watchTick;
		state == rest_pkg::ST_WATCH && codeTick && !overHit && anyUse && stillCount < stillnessTimeValue;
	endsequence

	reset_zero_a: assert property ($past(srst) |-> stillnessTimeValue == '0 && restUseAxis == '0
		&& restThreshold[0] == '0 && !restReferencedSelect)
		else $error("registers not zero after reset");
	reserved_read_a: assert property (regRdEn && regAddr == rest_pkg::ADDR_Y_LOW |=> regRdData[4:1] == 4'h0)
		else $error("reserved bits read nonzero");
	low_assemble_a: assert property (regWrEn && regAddr == rest_pkg::ADDR_Z_LOW
		|=> restThreshold[2][2:0] == $past(regWrData[7:5]) && restUseAxis[2] == $past(regWrData[0]))
		else $error("low threshold byte misplaced");
	ref_select_a: assert property (regWrEn && regAddr == rest_pkg::ADDR_X_LOW
		|=> restReferencedSelect == $past(regWrData[1]))
		else $error("processing select not taken");
	axis_gate_a: assert property (!restUseAxis[1] |-> !overAxis[1])
		else $error("excluded axis raised over threshold");
	over_restart_a: assert property (watchOver |=> stillCount == '0 ##1 state != rest_pkg::ST_STILL)
		else $error("over threshold did not restart timer");
	count_step_a: assert property (watchTick |=> stillCount == $past(stillCount) + CW'(1))
		else $error("stillness count did not advance");
	detect_time_a: assert property ($rose(restDetected) |-> $past(stillCount) >= $past(stillnessTimeValue)
		&& $past(anyUse))
		else $error("stillness reported before time elapsed");
	abs_compare_a: assert property (sampleValid && !restReferencedSelect && restUseAxis[0]
		&& sampleX == -12'sd5 && restThreshold[0] == 11'd5 |-> overAxis[0])
		else $error("magnitude compare wrong");
endmodule // accel_inactivity_detect
`default_nettype wire

/* File: design/rest_pkg.sv */
package rest_pkg;
	localparam int AXES = 3;
	localparam int THR_W = 11;
	localparam int SAMPLE_W = 12;
	localparam int COUNT_W = 16;
	localparam int REG_W = 8;

	localparam logic [7:0] ADDR_X_HIGH = 8'h2a;
	localparam logic [7:0] ADDR_X_LOW = 8'h2b;
	localparam logic [7:0] ADDR_Y_HIGH = 8'h2c;
	localparam logic [7:0] ADDR_Y_LOW = 8'h2d;
	localparam logic [7:0] ADDR_Z_HIGH = 8'h2e;
	localparam logic [7:0] ADDR_Z_LOW = 8'h2f;
	localparam logic [7:0] ADDR_TIME_HIGH = 8'h30;
	localparam logic [7:0] ADDR_TIME_LOW = 8'h31;
	localparam logic [7:0] ADDR_HIGH [AXES] = '{ADDR_X_HIGH, ADDR_Y_HIGH, ADDR_Z_HIGH};
	localparam logic [7:0] ADDR_LOW [AXES] = '{ADDR_X_LOW, ADDR_Y_LOW, ADDR_Z_LOW};

	localparam int THR_LOW_MSB = 7;
	localparam int THR_LOW_LSB = 5;
	localparam int REF_BIT = 1;
	localparam int USE_BIT = 0;
	localparam logic [7:0] REG_RESET = 8'h00;

	localparam int CLK_PERIOD_NS = 4;
	localparam int CODE_TIME_SLOW_MS = 26;
	localparam int CODE_TIME_FAST_MS = 13;
	localparam int CODE_CYCLES_SLOW = CODE_TIME_SLOW_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CODE_CYCLES_FAST = CODE_TIME_FAST_MS * 1000000 / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WATCH = 2'b01,
		ST_STILL = 2'b11
	} rest_state_t;
endpackage

/* File: design/code_tick_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module code_tick_divider #(
	parameter int SLOW_CYCLES = rest_pkg::CODE_CYCLES_SLOW,
	parameter int FAST_CYCLES = rest_pkg::CODE_CYCLES_FAST
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clear,
	input wire logic fast,
	output logic tick
);
	localparam int CNT_W = $clog2(SLOW_CYCLES + 1);

	generate
		if (FAST_CYCLES < 2 || SLOW_CYCLES < FAST_CYCLES) begin : g_bad
			$error("code_tick_divider: cycle counts out of range");
		end
	endgenerate

	logic [CNT_W-1:0] cnt;
	wire logic [CNT_W-1:0] limit = fast ? CNT_W'(FAST_CYCLES - 1) : CNT_W'(SLOW_CYCLES - 1);
	wire logic atLimit = (cnt >= limit);

	// one enable pulse per timer code, restarted by clear
	always_ff @(posedge sys_clk) begin
		if (srst || clear || atLimit) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		tick <= !srst && !clear && atLimit;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	tick_period_a: assert property (tick |-> $past(cnt) == $past(limit) && !$past(clear))
		else $error("code tick not at end of code period");
	tick_single_a: assert property (tick |=> !tick)
		else $error("code tick longer than one cycle");
endmodule // code_tick_divider
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic sys_clk,
	input wire logic [7:0] regRdData,
	output logic regWrEn,
	output logic regRdEn,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData
);
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end
	// one-cycle write strobe, lines scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge sys_clk);
		#1;
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	// read data is taken the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		regRdEn = 1'b1;
		regAddr = a;
		@(posedge sys_clk);
		#1;
		regRdEn = 1'b0;
		regAddr = ~a;
		d = regRdData;
	endtask
endmodule // host_model
`default_nettype wire

/* File: tb/accel_inactivity_detect_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module accel_inactivity_detect_bench;
	logic sys_clk, srst, regWrEn, regRdEn, outputDataRateFast, sampleValid;
	logic [7:0] regAddr, regWrData, regRdData, rdv;
	logic signed [11:0] sampleX, sampleY, sampleZ;
	logic restDetected, restEvent;
	logic [1:0] restState;
	int err_total = 0;
	int cmp_count = 0;

	accel_inactivity_detect #(.SLOW_CODE_CYCLES(20), .FAST_CODE_CYCLES(10)) dut (.sys_clk(sys_clk), .srst(srst),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.outputDataRateFast(outputDataRateFast), .sampleValid(sampleValid), .sampleX(sampleX),
		.sampleY(sampleY), .sampleZ(sampleZ), .restDetected(restDetected), .restEvent(restEvent),
		.restState(restState));
	host_model host (.sys_clk(sys_clk), .regRdData(regRdData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rdv);
		chk(rdv, exp, "register readback");
	endtask
	task automatic rst();
		@(posedge sys_clk);
		#1;
		srst = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		srst = 1'b0;
	endtask
	task automatic smp(input logic signed [11:0] x, input logic signed [11:0] y, input logic signed [11:0] z);
		@(posedge sys_clk);
		#1;
		sampleValid = 1'b1;
		sampleX = x;
		sampleY = y;
		sampleZ = z;
		@(posedge sys_clk);
		#1;
		sampleValid = 1'b0;
	endtask
	task automatic wait_det(input int lo, input int hi);
		int n;
		n = 0;
		while (restDetected !== 1'b1 && n < hi) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk({7'h00, restDetected}, 8'h01, "stillness not detected");
		chk({7'h00, restEvent}, 8'h01, "event missing");
		cmp_count++;
		if (n < lo) begin
			err_total++;
			$display("MISMATCH %0t stillness too early after %0d cycles", $time, n);
		end
		@(posedge sys_clk);
		#1;
		chk({7'h00, restEvent}, 8'h00, "event longer than one cycle");
		chk({6'h00, restState}, 8'h03, "state not still");
	endtask
	task automatic stay(input logic exp);
		repeat (3) @(posedge sys_clk);
		#1;
		chk({7'h00, restDetected}, {7'h00, exp}, "stillness flag");
	endtask

	task automatic t_reset();
		for (int a = 8'h2a; a <= 8'h31; a++) rdchk(a[7:0], 8'h00);
		rdchk(8'h40, 8'h00);
		chk({5'h00, restDetected, restState}, 8'h00, "outputs after reset");
	endtask
	task automatic t_regs();
		host.wr(8'h2b, 8'hff);
		rdchk(8'h2b, 8'he3);
		host.wr(8'h2d, 8'hff);
		rdchk(8'h2d, 8'he1);
		host.wr(8'h2f, 8'hff);
		rdchk(8'h2f, 8'he1);
		host.wr(8'h2a, 8'ha5);
		host.wr(8'h2c, 8'h5a);
		host.wr(8'h2e, 8'h3c);
		host.wr(8'h30, 8'h12);
		host.wr(8'h31, 8'h34);
		rdchk(8'h2a, 8'ha5);
		rdchk(8'h2c, 8'h5a);
		rdchk(8'h2e, 8'h3c);
		rdchk(8'h30, 8'h12);
		rdchk(8'h31, 8'h34);
	endtask
	task automatic t_zero();
		rst();
		host.wr(8'h2b, 8'ha1);
		smp(12'sd1, 12'sd2000, -12'sd2000);
		wait_det(0, 4);
		smp(-12'sd4, 12'sd0, 12'sd0);
		stay(1'b1);
		smp(-12'sd5, 12'sd0, 12'sd0);
		stay(1'b0);
		chk({6'h00, restState}, 8'h00, "state not idle");
	endtask
	task automatic t_timer(input logic fast, input logic [7:0] hiB, input logic [7:0] loB, input int lo, input int hi);
		rst();
		outputDataRateFast = fast;
		host.wr(8'h2b, 8'ha1);
		host.wr(8'h30, hiB);
		host.wr(8'h31, loB);
		smp(12'sd1, 12'sd0, 12'sd0);
		repeat (40) @(posedge sys_clk);
		smp(12'sd9, 12'sd0, 12'sd0);
		smp(12'sd1, 12'sd0, 12'sd0);
		wait_det(lo, hi);
	endtask
	task automatic t_ref();
		rst();
		outputDataRateFast = 1'b0;
		host.wr(8'h2d, 8'ha1);
		host.wr(8'h2b, 8'h02);
		// an idle sample is judged against the stored reference and then becomes it
		smp(12'sd900, 12'sd100, 12'sd0);
		smp(12'sd900, 12'sd100, 12'sd0);
		wait_det(0, 4);
		smp(12'sd0, 12'sd103, 12'sd0);
		stay(1'b1);
		smp(12'sd0, 12'sd105, 12'sd0);
		stay(1'b0);
	endtask

	task automatic stop_test();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#100000;
		err_total++;
		stop_test();
	end

	initial begin
		srst = 1'b1;
		outputDataRateFast = 1'b0;
		sampleValid = 1'b0;
		sampleX = 12'sd0;
		sampleY = 12'sd0;
		sampleZ = 12'sd0;
		rst();
		t_reset();
		t_regs();
		t_zero();
		t_timer(1'b0, 8'h00, 8'h04, 60, 100);
		t_timer(1'b1, 8'h01, 8'h00, 2540, 2590);
		t_ref();
		stop_test();
	end
endmodule // accel_inactivity_detect_bench
`default_nettype wire
